/* File: serial_shifter_pkg.sv */
// constants and register layout of the clocked serial shifter
package serial_shifter_pkg;
    localparam logic [4:0] mode_clock_control_off = 5'h00;
    localparam logic [4:0] control_status_off = 5'h04;
    localparam logic [4:0] data_upper_off = 5'h08;
    localparam logic [4:0] data_lower_off = 5'h0c;
    localparam logic [4:0] interrupt_request_off = 5'h10;
    localparam logic [7:0] mode_clock_control_rst = 8'h00;
    localparam logic [7:0] control_status_rst = 8'h80;
    localparam int op_mode_upper_pos = 7;
    localparam int op_mode_lower_pos = 6;
    localparam int clock_source_pos = 3;
    localparam int output_level_pos = 6;
    localparam int overrun_pos = 5;
    localparam int start_pos = 0;
    localparam int request_pos = 0;
    localparam int irq_enable_pos = 1;
    localparam logic [1:0] mode_continuous = 2'b10;
    localparam int prescale_width = 10;
    localparam logic [1:0] axi_okay = 2'b00;
    localparam logic [1:0] axi_slverr = 2'b10;
    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_run = 3'b010,
        st_done = 3'b100
    } shift_state_t;
endpackage : serial_shifter_pkg

/* File: serial_clock_prescaler.sv */
// free-running prescaler that makes internal serial clock edge pulses
`timescale 1ns/1ps
module serial_clock_prescaler
    import serial_shifter_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [2:0] divider_sel,
    output logic rise_pulse,
    output logic fall_pulse,
    output logic level
);
    logic [prescale_width-1:0] count_q;
    logic [3:0] tap;
    logic tap_bit;
    logic [prescale_width-1:0] low_mask;
    logic low_full;

    // code 0 is /1024 down to code 7 which is /2; the level is one counter bit
    always_comb begin
        case (divider_sel)
            3'd0: tap = 4'd9;
            3'd1: tap = 4'd7;
            3'd2: tap = 4'd5;
            3'd3: tap = 4'd4;
            3'd4: tap = 4'd3;
            3'd5: tap = 4'd2;
            3'd6: tap = 4'd1;
            default: tap = 4'd0;
        endcase
    end
    assign tap_bit = count_q[tap];
    assign level = tap_bit;

    // counter runs always so continuous mode never stutters
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + prescale_width'(1);
        end
    end

    // edges come one cycle ahead of the level flip: all bits below the tap are ones
    assign low_mask = (prescale_width'(1) << tap) - prescale_width'(1);
    assign low_full = (count_q & low_mask) == low_mask;
    assign rise_pulse = !tap_bit && low_full;
    assign fall_pulse = tap_bit && low_full;
endmodule : serial_clock_prescaler

/* File: clocked_serial_shifter.sv */
// clocked serial shifter with axi4-lite registers
`timescale 1ns/1ps
module clocked_serial_shifter
    import serial_shifter_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe,
    input wire logic serial_in_pin,
    output logic serial_out_pin,
    output logic transfer_done_irq
);
    logic [7:0] mode_clock_control_q;
    logic output_level_q;
    logic overrun_q;
    logic overrun_seen_q;
    logic [15:0] shift_q;
    logic [4:0] bit_count_q;
    logic request_q;
    logic irq_enable_q;
    shift_state_t state_q;
    logic sck_meta_q;
    logic sck_sync_q;
    logic sck_prev_q;
    logic sck_out_q;
    logic [4:0] aw_addr_q;
    logic aw_have_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic w_have_q;
    logic wr_fire;
    logic int_rise;
    logic int_fall;
    logic int_level;
    logic ext_rise;
    logic ext_fall;
    logic use_ext;
    logic sh_rise;
    logic sh_fall;
    logic shift_rise;
    logic fell_q;
    logic request_d;
    logic irq_enable_d;
    logic [4:0] word_bits;
    logic wr_mode;
    logic wr_status;
    logic wr_upper;
    logic wr_lower;
    logic wr_request;
    logic start_req;
    logic done_evt;
    logic [7:0] rd_byte;
    logic rd_ok;

    serial_clock_prescaler u_prescaler (
        .aclk(aclk),
        .aresetn(aresetn),
        .divider_sel(mode_clock_control_q[2:0]),
        .rise_pulse(int_rise),
        .fall_pulse(int_fall),
        .level(int_level)
    );

    // decode helper shared by read and write
    function automatic logic addr_is(input logic [4:0] a, input logic [4:0] off);
        addr_is = (a[4:2] == off[4:2]);
    endfunction : addr_is

    // ---- write channel: take address and data in either order
    assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= '0;
            w_strb_q <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= axi_okay;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (aw_addr_q[4] && aw_addr_q[3:2] != 2'd0) ? axi_slverr : axi_okay;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // byte lane 0 carries every register
    assign wr_mode = wr_fire && w_strb_q[0] && addr_is(aw_addr_q, mode_clock_control_off);
    assign wr_status = wr_fire && w_strb_q[0] && addr_is(aw_addr_q, control_status_off);
    assign wr_upper = wr_fire && w_strb_q[0] && addr_is(aw_addr_q, data_upper_off);
    assign wr_lower = wr_fire && w_strb_q[0] && addr_is(aw_addr_q, data_lower_off);
    assign wr_request = wr_fire && w_strb_q[0] && addr_is(aw_addr_q, interrupt_request_off);
    assign start_req = wr_status && w_data_q[start_pos];

    // ---- mode/clock control register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_clock_control_q <= mode_clock_control_rst;
        end else if (wr_mode) begin
            mode_clock_control_q <= {w_data_q[7:6], 2'b00, w_data_q[3:0]};
        end
    end

    // ---- external clock: two-flop sync then edge detect on the second flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_meta_q <= 1'b1;
            sck_sync_q <= 1'b1;
            sck_prev_q <= 1'b1;
        end else begin
            sck_meta_q <= serial_clock_pin_i;
            sck_sync_q <= sck_meta_q;
            sck_prev_q <= sck_sync_q;
        end
    end
    assign ext_rise = sck_sync_q && !sck_prev_q;
    assign ext_fall = !sck_sync_q && sck_prev_q;

    assign use_ext = mode_clock_control_q[clock_source_pos];
    assign sh_rise = use_ext ? ext_rise : int_rise;
    assign sh_fall = use_ext ? ext_fall : int_fall;
    assign word_bits = mode_clock_control_q[op_mode_lower_pos] ? 5'd16 : 5'd8;

    // ---- sequencer: idle, running a word, done
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= st_idle;
            bit_count_q <= '0;
        end else if (wr_mode) begin
            state_q <= st_idle;
            bit_count_q <= '0;
        end else begin
            case (state_q)
                st_idle, st_done: begin
                    if (start_req && mode_clock_control_q[op_mode_upper_pos] == 1'b0) begin
                        state_q <= st_run;
                        bit_count_q <= '0;
                    end
                end
                st_run: begin
                    // word ends on the rising edge that samples its last bit
                    if (shift_rise) begin
                        bit_count_q <= bit_count_q + 5'd1;
                        if (bit_count_q == word_bits - 5'd1) begin
                            state_q <= st_done;
                        end
                    end
                end
                default: begin
                    state_q <= st_idle;
                end
            endcase
        end
    end
    assign done_evt = state_q == st_run && shift_rise && bit_count_q == word_bits - 5'd1 && !wr_mode;

    // a word opens on a falling edge; a rise before it would sample a bit the far side never saw
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fell_q <= 1'b0;
        end else if (wr_mode || state_q != st_run) begin
            fell_q <= 1'b0;
        end else if (sh_fall) begin
            fell_q <= 1'b1;
        end
    end
    assign shift_rise = sh_rise && fell_q;

    // ---- shift register and data bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            shift_q <= '0;
        end else if (state_q == st_run && shift_rise && !wr_mode) begin
            // lsb leaves first; the sampled bit enters at the top of the word
            if (word_bits == 5'd16) begin
                shift_q <= {serial_in_pin, shift_q[15:1]};
            end else begin
                shift_q <= {shift_q[15:8], serial_in_pin, shift_q[7:1]};
            end
        end else begin
            if (wr_upper) begin
                shift_q[15:8] <= w_data_q[7:0];
            end
            if (wr_lower) begin
                shift_q[7:0] <= w_data_q[7:0];
            end
        end
    end

    // ---- data output: bit 0 goes out on falling edges, level write while stopped
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_level_q <= 1'b0;
        end else if (state_q == st_run && sh_fall && !wr_mode) begin
            output_level_q <= shift_q[0];
        end else if (wr_status && state_q != st_run) begin
            output_level_q <= w_data_q[output_level_pos];
        end
    end
    // pin keeps last bit after the word until a status write while stopped moves it
    assign serial_out_pin = output_level_q;

    // ---- overrun: external rising edge in the done state after a word; set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            overrun_q <= 1'b0;
            overrun_seen_q <= 1'b0;
        end else begin
            if (s_axi_arvalid && s_axi_arready && addr_is(s_axi_araddr, control_status_off) && overrun_q) begin
                overrun_seen_q <= 1'b1;
            end
            if (use_ext && state_q == st_done && ext_rise) begin
                overrun_q <= 1'b1;
            end else if (wr_status && !w_data_q[overrun_pos] && overrun_seen_q) begin
                overrun_q <= 1'b0;
                overrun_seen_q <= 1'b0;
            end
        end
    end

    // ---- request flag and its enable; set wins over software clear
    always_comb begin
        request_d = request_q;
        irq_enable_d = irq_enable_q;
        if (wr_request) begin
            irq_enable_d = w_data_q[irq_enable_pos];
            if (!w_data_q[request_pos]) begin
                request_d = 1'b0;
            end
        end
        if (done_evt) begin
            request_d = 1'b1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            request_q <= 1'b0;
            irq_enable_q <= 1'b0;
        end else begin
            request_q <= request_d;
            irq_enable_q <= irq_enable_d;
        end
    end
    // the line follows the next values so a clear drops it in the same cycle as the flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            transfer_done_irq <= 1'b0;
        end else begin
            transfer_done_irq <= request_d && irq_enable_d;
        end
    end

    // ---- clock pin: driven for internal source, gated to the word unless continuous
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sck_out_q <= 1'b1;
            serial_clock_pin_oe <= 1'b1;
        end else begin
            serial_clock_pin_oe <= !use_ext;
            if (mode_clock_control_q[7:6] == mode_continuous) begin
                sck_out_q <= int_level;
            end else if (state_q == st_run && !use_ext) begin
                // the pin idles high, so a word shows falls then rises in step with data
                if (int_fall) begin
                    sck_out_q <= 1'b0;
                end else if (int_rise) begin
                    sck_out_q <= 1'b1;
                end
            end else begin
                sck_out_q <= 1'b1;
            end
        end
    end
    assign serial_clock_pin_o = sck_out_q;

    // ---- read channel, one cycle answer
    always_comb begin
        rd_ok = 1'b1;
        rd_byte = 8'h00;
        case (s_axi_araddr[4:2])
            3'd0: rd_byte = mode_clock_control_q;
            3'd1: rd_byte = {1'b1, output_level_q, overrun_q, 4'h0, state_q == st_run};
            3'd2: rd_byte = shift_q[15:8];
            3'd3: rd_byte = shift_q[7:0];
            3'd4: rd_byte = {6'h00, irq_enable_q, request_q};
            default: rd_ok = 1'b0;
        endcase
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= axi_okay;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_byte};
                s_axi_rresp <= rd_ok ? axi_okay : axi_slverr;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule : clocked_serial_shifter

/* File: clocked_serial_shifter_asserts.sv */
// concurrent checks on the shifter's bus and serial pin ports
`timescale 1ns/1ps
module clocked_serial_shifter_asserts
    import serial_shifter_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic serial_clock_pin_o,
    input wire logic serial_clock_pin_oe,
    input wire logic serial_out_pin
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write channels taken at one edge
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    // answers stand until the master takes them
    bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    read_cause_a: assert property (!s_axi_rvalid && !(s_axi_arvalid && s_axi_arready) |=> !s_axi_rvalid)
        else $error("read answer without request");
    write_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write answer late");
    // unmapped places answer with an error, mapped ones do not
    read_error_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 5'h10 |=> s_axi_rresp == axi_slverr)
        else $error("unmapped read not refused");
    read_okay_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr <= 5'h10 |=> s_axi_rresp == axi_okay)
        else $error("mapped read refused");
    write_error_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        && s_axi_awaddr > 5'h10 |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == axi_slverr))
        else $error("unmapped write not refused");
    aw_once_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("second write address taken");
    // within a word data only moves on falling clock edges, so a rising edge there never sees it change
    out_rise_a: assert property ($rose(serial_clock_pin_o) && serial_clock_pin_oe |-> $stable(serial_out_pin))
        else $error("data output moved on rising clock");
endmodule : clocked_serial_shifter_asserts

/* File: serial_partner.sv */
// far-side serial device: shifts one word in and out lsb first
`timescale 1ns/1ps
module serial_partner (
    input wire logic sck,
    input wire logic so,
    input wire logic load,
    input wire logic [15:0] tx_word,
    output logic si,
    output logic [15:0] rx_word
);
    int idx = 0;
    initial si = 1'b0;
    initial rx_word = 16'h0000;
    // a new word shows its first bit before any clock edge
    always @(posedge load) begin
        idx = 0;
        si = tx_word[0];
    end
    // capture on the rising edge
    always @(posedge sck) begin
        rx_word = {so, rx_word[15:1]};
        idx = idx + 1;
    end
    // past the word the line toggles so stale data never looks valid
    always @(negedge sck) begin
        si = (idx < 16) ? tx_word[idx] : ~si;
    end
endmodule : serial_partner

/* File: clocked_serial_shifter_tb.sv */
// self-checking bench for the clocked serial shifter
`timescale 1ns/1ps
module clocked_serial_shifter_tb;
    import serial_shifter_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, ext_sck, p_load;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serial_in_pin;
    logic serial_clock_pin_o, serial_clock_pin_oe, serial_out_pin, transfer_done_irq;
    logic [4:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] p_tx, p_rx;
    logic [31:0] seed = 32'hfed5;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    int divs[8] = '{1024, 256, 64, 32, 16, 8, 4, 2};
    // the pin level comes from whoever drives it
    wire serial_clock_pin_i = serial_clock_pin_oe ? serial_clock_pin_o : ext_sck;

    clocked_serial_shifter dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .serial_clock_pin_i, .serial_clock_pin_o, .serial_clock_pin_oe, .serial_in_pin, .serial_out_pin,
        .transfer_done_irq);
    serial_partner partner (.sck(serial_clock_pin_i), .so(serial_out_pin), .load(p_load), .tx_word(p_tx),
        .si(serial_in_pin), .rx_word(p_rx));

    always #2.5 aclk = ~aclk;
    // hang guard
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            $display("Error at %0t: timeout", $time);
            give_verdict();
        end
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : xs

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // write: both channels offered together, each released once taken
    task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        d = s_axi_rdata[7:0];
        check(32'(s_axi_rresp), 32'(er));
    endtask : rd

    task automatic rchk(input logic [4:0] a, input logic [7:0] e);
        logic [7:0] d;
        rd(a, d, axi_okay);
        check(32'(d), 32'(e));
    endtask : rchk

    task automatic count_rises(input int n, output int r);
        logic p;
        r = 0;
        p = serial_clock_pin_o;
        repeat (n) begin
            @(posedge aclk);
            if (serial_clock_pin_o && !p) r++;
            p = serial_clock_pin_o;
        end
    endtask : count_rises

    // one external clock pulse, slow enough for the synchroniser
    task automatic ext_pulse();
        repeat (8) @(posedge aclk);
        ext_sck <= 1'b0;
        repeat (8) @(posedge aclk);
        ext_sck <= 1'b1;
    endtask : ext_pulse

    task automatic xfer(input logic wide, input logic ext, input logic en);
        logic [15:0] dtx;
        logic [15:0] ptx;
        logic [7:0] d;
        logic lvl;
        int n;
        int r;
        dtx = 16'(xs());
        ptx = 16'(xs());
        n = wide ? 16 : 8;
        lvl = dtx[n - 1];
        wr(5'h00, {1'b0, wide, 2'b00, ext, 3'(5 + xs() % 3)}, axi_okay);
        wr(5'h08, dtx[15:8], axi_okay);
        wr(5'h0c, dtx[7:0], axi_okay);
        wr(5'h10, {6'h0, en, 1'b0}, axi_okay);
        @(posedge aclk);
        p_tx <= ptx;
        p_load <= 1'b1;
        @(posedge aclk);
        p_load <= 1'b0;
        wr(5'h04, 8'h01, axi_okay);
        check(32'(serial_clock_pin_oe), 32'(!ext));
        if (ext) repeat (n) ext_pulse();
        d = 8'h00;
        // poll the request register only, never the status register mid-word
        while (!d[0]) rd(5'h10, d, axi_okay);
        check(32'(d), {30'h0, en, 1'b1});
        check(32'(transfer_done_irq), 32'(en));
        rchk(5'h04, {1'b1, lvl, 6'h00});
        check(32'(serial_out_pin), 32'(lvl));
        rchk(5'h0c, ptx[7:0]);
        if (wide) rchk(5'h08, ptx[15:8]);
        check(32'(wide ? p_rx : {8'h0, p_rx[15:8]}), 32'(wide ? dtx : {8'h0, dtx[7:0]}));
        if (!ext) begin
            count_rises(64, r);
            check(32'(r), 32'h0);
        end else begin
            ext_pulse();
            repeat (4) @(posedge aclk);
            wr(5'h04, {1'b0, lvl, 6'h20}, axi_okay);
            rchk(5'h04, {1'b1, lvl, 6'h20});
            rchk(5'h0c, ptx[7:0]);
            wr(5'h04, {1'b0, !lvl, 6'h00}, axi_okay);
            rchk(5'h04, {1'b1, !lvl, 6'h00});
            check(32'(serial_out_pin), 32'(!lvl));
        end
    endtask : xfer

    task automatic give_verdict();
        if (bad_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // main sequence
    initial begin
        logic [7:0] d;
        int r;
        aclk = 1'b0;
        aresetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, p_load} = 6'h00;
        ext_sck = 1'b1;
        s_axi_awaddr = 5'h00;
        s_axi_araddr = 5'h00;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hf;
        p_tx = 16'h0000;
        repeat (12) @(posedge aclk);
        check({28'h0, serial_clock_pin_oe, serial_clock_pin_o, serial_out_pin, transfer_done_irq}, 32'hc);
        aresetn <= 1'b1;
        rchk(5'h00, mode_clock_control_rst);
        rchk(5'h04, control_status_rst);
        rd(5'h14, d, axi_slverr);
        wr(5'h18, 8'h5a, axi_slverr);
        rchk(5'h00, 8'h00);
        for (int k = 0; k < 4; k++) xfer(k[0], k[1], k[0] ^ k[1]);
        // abort a slow transfer by rewriting the mode register
        wr(5'h00, 8'h00, axi_okay);
        wr(5'h10, 8'h00, axi_okay);
        wr(5'h04, 8'h01, axi_okay);
        repeat (1500) @(posedge aclk);
        wr(5'h00, 8'h00, axi_okay);
        rd(5'h04, d, axi_okay);
        check(32'(d[0]), 32'h0);
        count_rises(2100, r);
        check(32'(r), 32'h0);
        rchk(5'h10, 8'h00);
        // continuous clock at every divider, counted over four periods
        for (int k = 0; k < 8; k++) begin
            wr(5'h00, {5'b10000, 3'(k)}, axi_okay);
            repeat (divs[k] + 8) @(posedge aclk);
            count_rises(4 * divs[k], r);
            check(32'(r), 32'h4);
            check(32'(serial_clock_pin_oe), 32'h1);
        end
        give_verdict();
    end
endmodule : clocked_serial_shifter_tb

bind clocked_serial_shifter clocked_serial_shifter_asserts u_chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .serial_clock_pin_o, .serial_clock_pin_oe, .serial_out_pin);
